// >>> rtl/converter_sync_startup.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "conv_map.svh"
module converter_sync_startup #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite register bus
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Transmit request, sync sources and alarm events
  input wire logic tx_enable_pin,
  input wire logic lvds_sync_input,
  input wire logic lvds_frame_input,
  input wire logic output_strobe,
  input wire logic dataclk_lost,
  input wire logic dacclk_lost,
  input wire logic fifo_collision,
  input wire logic pll_unlock,
  // Transmit and alarm status
  output logic tx_active,
  output logic output_shutoff,
  output logic alarm_out,
  // Sync pulses to the datapath blocks
  output logic fifo_wr_ptr_sync,
  output logic fifo_rd_ptr_sync,
  output logic formatter_sync,
  output logic clkdiv_sync,
  output logic pll_ndiv_sync,
  output logic qmc_offset_ab_sync,
  output logic qmc_offset_cd_sync,
  output logic qmc_corr_ab_sync,
  output logic qmc_corr_cd_sync,
  output logic nco_ab_sync,
  output logic nco_cd_sync,
  // Configuration fields
  output conv_pkg::freq_word_t oscillator_frequency_word_ab,
  output conv_pkg::freq_word_t oscillator_frequency_word_cd,
  output logic [7:0] pll_ref_div_m,
  output logic [4:0] pll_fb_div_n,
  output logic [1:0] pll_vco_bias,
  output logic [3:0] coarse_mixer_mode,
  output logic [2:0] fifo_offset
);
  import conv_pkg::*;

  // Register storage and alarm state
  reg_word_t regs [0:`REG_COUNT-1];
  reg_word_t alarm_reg;
  reg_word_t alarm_next;
  reg_word_t set_bits;
  reg_word_t status_word;

  // Transmit state
  tx_state_t tx_state_reg;
  tx_state_t tx_state_next;

  // Bus data-phase tracking
  reg_idx_t idx_reg;
  reg_idx_t addr_idx;
  logic wr_pend_reg;
  logic wr_en;
  logic addr_take;
  logic addr_high_zero;

  // Edge detection and derived conditions
  logic frame_prev_reg;
  logic sync_prev_reg;
  logic output_strobe_prev_reg;
  logic shut_cond;
  logic tx_request;
  logic alarm_active;

  sync_if sr_bus ();

  // Register indices that answer on the bus
  function automatic logic is_mapped(input reg_idx_t idx);
    unique case (idx)
      `IDX_MAIN_CONFIG, `IDX_PARITY_ALARM, `IDX_SHUTOFF_MIXER, `IDX_OUTPUT_CURRENT,
      `IDX_ALARM_STATUS, `IDX_FORMATTER_SEL, `IDX_SYNC_SELECT, `IDX_STATUS: is_mapped = 1'b1;
      default: is_mapped = (idx >= `IDX_ALARM_MASK) && (idx <= `IDX_PLL_DIVIDER);
    endcase
  endfunction : is_mapped

  // Indices backed by the plain storage array
  function automatic logic is_plain(input reg_idx_t idx);
    is_plain = is_mapped(idx) && (idx != `IDX_ALARM_STATUS) && (idx != `IDX_STATUS);
  endfunction : is_plain

  // Reset value of each plain register
  function automatic reg_word_t reset_value(input int idx);
    unique case (idx)
      0: reset_value = `RST_MAIN_CONFIG;
      1: reset_value = `RST_PARITY_ALARM;
      2: reset_value = `RST_SHUTOFF_MIXER;
      3: reset_value = `RST_OUTPUT_CURRENT;
      7: reset_value = `RST_ALARM_MASK;
      default: reset_value = 16'h0000;
    endcase
  endfunction : reset_value

  // Bus address phase decode; words are aligned, index is address over four
  assign addr_high_zero = (haddr[ADDR_W-1:2] >> 6) == '0;
  assign addr_idx = reg_idx_t'(haddr[ADDR_W-1:2]);
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_en = wr_pend_reg;

  // Zero-wait slave, every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Capture of the address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      idx_reg <= 6'h00;
    end else begin
      wr_pend_reg <= addr_take & hwrite & addr_high_zero & is_mapped(addr_idx);
      if (addr_take) begin
        idx_reg <= addr_idx;
      end
    end
  end

  // Word returned for a read, with a pending write to the same index forwarded
  function automatic reg_word_t read_word(input reg_idx_t idx);
    if (!is_mapped(idx)) begin
      read_word = 16'h0000;
    end else if (idx == `IDX_ALARM_STATUS) begin
      read_word = alarm_next;
    end else if (idx == `IDX_STATUS) begin
      read_word = status_word;
    end else if (wr_en && idx_reg == idx) begin
      read_word = hwdata[15:0];
    end else begin
      read_word = regs[idx];
    end
  endfunction : read_word

  // Read data registered at the address phase, upper half reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= addr_high_zero ? {16'h0000, read_word(addr_idx)} : 32'h0000_0000;
    end
  end

  // Plain configuration storage; unmapped and read-only indices ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs[i] <= reset_value(i);
      end
    end else if (wr_en && is_plain(idx_reg)) begin
      regs[idx_reg] <= hwdata[15:0];
    end
  end

  // Sticky alarms; a hardware event in the clearing cycle wins
  always_comb begin
    set_bits = 16'h0000;
    set_bits[`BIT_ALM_COLLISION] = fifo_collision;
    set_bits[`BIT_ALM_DACCLK] = dacclk_lost;
    set_bits[`BIT_ALM_DATACLK] = dataclk_lost;
    set_bits[`BIT_ALM_PLL_UNLOCK] = pll_unlock;
    alarm_next = ((wr_en && idx_reg == `IDX_ALARM_STATUS) ? hwdata[15:0] : alarm_reg) | set_bits;
  end

  // Alarm status register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_reg <= 16'h0000;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  // Unmasked alarms drive the alarm pin, gated by enable and polarity
  assign alarm_active = |(alarm_reg & ~regs[`IDX_ALARM_MASK]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= regs[`IDX_MAIN_CONFIG][`BIT_ALARM_OUT_POL] ?
                   (regs[`IDX_MAIN_CONFIG][`BIT_ALARM_OUT_ENA] & alarm_active) :
                   !(regs[`IDX_MAIN_CONFIG][`BIT_ALARM_OUT_ENA] & alarm_active);
    end
  end

  // Output shut-off on enabled clock-loss or collision alarms
  always_comb begin
    shut_cond = (regs[`IDX_SHUTOFF_MIXER][`BIT_SHUT_DACCLK] & alarm_reg[`BIT_ALM_DACCLK]) |
                (regs[`IDX_SHUTOFF_MIXER][`BIT_SHUT_DATACLK] & alarm_reg[`BIT_ALM_DATACLK]) |
                (regs[`IDX_SHUTOFF_MIXER][`BIT_SHUT_COLLISION] & alarm_reg[`BIT_ALM_COLLISION]);
  end

  // Registered shut-off flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_shutoff <= 1'b0;
    end else begin
      output_shutoff <= shut_cond;
    end
  end

  // Transmit request from the pin or the register bit
  assign tx_request = tx_enable_pin | regs[`IDX_OUTPUT_CURRENT][`BIT_SIF_TXENABLE];

  // Transmit state: a halt after shut-off needs the request dropped first
  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      TX_IDLE: begin
        if (tx_request && !shut_cond) begin
          tx_state_next = TX_RUN;
        end
      end
      TX_RUN: begin
        if (shut_cond) begin
          tx_state_next = TX_HALT;
        end else if (!tx_request) begin
          tx_state_next = TX_IDLE;
        end
      end
      TX_HALT: begin
        if (!tx_request && !shut_cond) begin
          tx_state_next = TX_IDLE;
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
  end

  // State and the registered transmit flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= TX_IDLE;
      tx_active <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_active <= (tx_state_next == TX_RUN);
    end
  end

  // Read-only status word
  assign status_word = {10'h000, tx_state_reg, output_shutoff, alarm_out, tx_active};

  // Edge detection on the synchronous sync, frame and strobe inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
      output_strobe_prev_reg <= 1'b0;
    end else begin
      frame_prev_reg <= lvds_frame_input;
      sync_prev_reg <= lvds_sync_input;
      output_strobe_prev_reg <= output_strobe;
    end
  end

  // Rising edges of the frame, sync and strobe inputs handed to the sync router
  assign sr_bus.frame_rise = lvds_frame_input & ~frame_prev_reg;
  assign sr_bus.sync_rise = lvds_sync_input & ~sync_prev_reg;
  assign sr_bus.output_strobe_rise = output_strobe & ~output_strobe_prev_reg;

  // Select and enable fields from the configuration words
  assign sr_bus.sel_fifo_in = regs[`IDX_SYNC_SELECT][`FLD_FIFO_IN_HI:`FLD_FIFO_IN_LO];
  assign sr_bus.sel_fifo_out = regs[`IDX_SYNC_SELECT][`FLD_FIFO_OUT_HI:`FLD_FIFO_OUT_LO];
  assign sr_bus.sel_fmt = regs[`IDX_FORMATTER_SEL][`FLD_FMT_SEL_HI:`FLD_FMT_SEL_LO];
  assign sr_bus.clkdiv_sel = regs[`IDX_SYNC_SELECT][`BIT_CLKDIV_SEL];
  assign sr_bus.clkdiv_ena = regs[`IDX_MAIN_CONFIG][`BIT_CLKDIV_SYNC_ENA];
  assign sr_bus.ndiv_ena = regs[`IDX_PLL_CONTROL][`BIT_NDIV_SYNC_ENA];

  sync_router u_router (
    .hclk(hclk),
    .hresetn(hresetn),
    .sr(sr_bus.router)
  );

  // Router pulses out to the pins
  assign fifo_wr_ptr_sync = sr_bus.wr_ptr_sync;
  assign fifo_rd_ptr_sync = sr_bus.rd_ptr_sync;
  assign formatter_sync = sr_bus.fmt_sync;
  assign clkdiv_sync = sr_bus.clkdiv_sync;
  assign pll_ndiv_sync = sr_bus.ndiv_sync;

  // Auto-sync pulses, one cycle after the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qmc_offset_ab_sync <= 1'b0;
      qmc_offset_cd_sync <= 1'b0;
      qmc_corr_ab_sync <= 1'b0;
      qmc_corr_cd_sync <= 1'b0;
      nco_ab_sync <= 1'b0;
      nco_cd_sync <= 1'b0;
    end else begin
      qmc_offset_ab_sync <= wr_en && idx_reg == `IDX_IQ_OFFSET_A;
      qmc_offset_cd_sync <= wr_en && idx_reg == `IDX_IQ_OFFSET_C;
      qmc_corr_ab_sync <= wr_en && idx_reg == `IDX_IQ_PHASE_AB;
      qmc_corr_cd_sync <= wr_en && idx_reg == `IDX_IQ_PHASE_CD;
      nco_ab_sync <= wr_en && idx_reg == `IDX_OSC_PHASE_AB;
      nco_cd_sync <= wr_en && idx_reg == `IDX_OSC_PHASE_CD;
    end
  end

  // Field outputs registered from the configuration words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oscillator_frequency_word_ab <= 32'h0000_0000;
      oscillator_frequency_word_cd <= 32'h0000_0000;
      pll_ref_div_m <= 8'h00;
      pll_fb_div_n <= 5'h00;
      pll_vco_bias <= 2'h0;
      coarse_mixer_mode <= 4'h0;
      fifo_offset <= 3'h0;
    end else begin
      // Low half at the lower index
      oscillator_frequency_word_ab <= {regs[`IDX_OSC_FREQ_AB_HI], regs[`IDX_OSC_FREQ_AB_LO]};
      oscillator_frequency_word_cd <= {regs[`IDX_OSC_FREQ_CD_HI], regs[`IDX_OSC_FREQ_CD_LO]};
      // PLL divider fields
      pll_ref_div_m <= regs[`IDX_PLL_DIVIDER][`FLD_PLL_M_HI:`FLD_PLL_M_LO];
      // Field holds N minus one
      pll_fb_div_n <= {1'b0, regs[`IDX_PLL_DIVIDER][`FLD_PLL_N_HI:`FLD_PLL_N_LO]} + 5'h01;
      pll_vco_bias <= regs[`IDX_PLL_DIVIDER][`FLD_VCO_BIAS_HI:`FLD_VCO_BIAS_LO];
      // Fields sharing a word with channel B settings
      coarse_mixer_mode <= regs[`IDX_MIXER_GAIN_B][`FLD_MIX_MODE_HI:`FLD_MIX_MODE_LO];
      fifo_offset <= regs[`IDX_FIFO_OFS_B][`FLD_FIFO_OFS_HI:`FLD_FIFO_OFS_LO];
    end
  end

endmodule : converter_sync_startup
`default_nettype wire

// >>> rtl/conv_map.svh
`ifndef CONV_MAP_SVH
`define CONV_MAP_SVH
`define REG_COUNT 33
`define IDX_MAIN_CONFIG 6'h00
`define IDX_PARITY_ALARM 6'h01
`define IDX_SHUTOFF_MIXER 6'h02
`define IDX_OUTPUT_CURRENT 6'h03
`define IDX_ALARM_STATUS 6'h05
`define IDX_ALARM_MASK 6'h07
`define IDX_IQ_OFFSET_A 6'h08
`define IDX_FIFO_OFS_B 6'h09
`define IDX_IQ_OFFSET_C 6'h0a
`define IDX_MIXER_GAIN_B 6'h0d
`define IDX_IQ_PHASE_AB 6'h10
`define IDX_IQ_PHASE_CD 6'h11
`define IDX_OSC_PHASE_AB 6'h12
`define IDX_OSC_PHASE_CD 6'h13
`define IDX_OSC_FREQ_AB_LO 6'h14
`define IDX_OSC_FREQ_AB_HI 6'h15
`define IDX_OSC_FREQ_CD_LO 6'h16
`define IDX_OSC_FREQ_CD_HI 6'h17
`define IDX_PLL_CONTROL 6'h18
`define IDX_PLL_DIVIDER 6'h19
`define IDX_FORMATTER_SEL 6'h1f
`define IDX_SYNC_SELECT 6'h20
`define IDX_STATUS 6'h21
`define RST_MAIN_CONFIG 16'h049c
`define RST_PARITY_ALARM 16'h050e
`define RST_SHUTOFF_MIXER 16'h7000
`define RST_OUTPUT_CURRENT 16'hf000
`define RST_ALARM_MASK 16'hffff
`define BIT_CLKDIV_SYNC_ENA 2
`define BIT_ALARM_OUT_ENA 4
`define BIT_ALARM_OUT_POL 3
`define BIT_SIF_TXENABLE 0
`define BIT_SHUT_DACCLK 14
`define BIT_SHUT_DATACLK 13
`define BIT_SHUT_COLLISION 12
`define BIT_NDIV_SYNC_ENA 11
`define BIT_ALM_PLL_UNLOCK 12
`define BIT_ALM_COLLISION 13
`define BIT_ALM_DACCLK 10
`define BIT_ALM_DATACLK 9
`define FLD_FIFO_IN_HI 15
`define FLD_FIFO_IN_LO 12
`define FLD_FIFO_OUT_HI 11
`define FLD_FIFO_OUT_LO 8
`define BIT_CLKDIV_SEL 0
`define FLD_FMT_SEL_HI 3
`define FLD_FMT_SEL_LO 2
`define FLD_FIFO_OFS_HI 15
`define FLD_FIFO_OFS_LO 13
`define FLD_MIX_MODE_HI 15
`define FLD_MIX_MODE_LO 12
`define FLD_PLL_M_HI 15
`define FLD_PLL_M_LO 8
`define FLD_PLL_N_HI 7
`define FLD_PLL_N_LO 4
`define FLD_VCO_BIAS_HI 3
`define FLD_VCO_BIAS_LO 2
`endif

// >>> rtl/conv_pkg.sv
package conv_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [5:0] reg_idx_t;
  typedef logic [31:0] freq_word_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_RUN = 3'b010,
    TX_HALT = 3'b100
  } tx_state_t;
endpackage : conv_pkg

// >>> rtl/sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sync_if;
  logic frame_rise;
  logic sync_rise;
  logic output_strobe_rise;
  logic [3:0] sel_fifo_in;
  logic [3:0] sel_fifo_out;
  logic [1:0] sel_fmt;
  logic clkdiv_sel;
  logic clkdiv_ena;
  logic ndiv_ena;
  logic wr_ptr_sync;
  logic rd_ptr_sync;
  logic fmt_sync;
  logic clkdiv_sync;
  logic ndiv_sync;
  modport cfg (output frame_rise, sync_rise, output_strobe_rise, sel_fifo_in, sel_fifo_out, sel_fmt,
               clkdiv_sel, clkdiv_ena, ndiv_ena,
               input wr_ptr_sync, rd_ptr_sync, fmt_sync, clkdiv_sync, ndiv_sync);
  modport router (input frame_rise, sync_rise, output_strobe_rise, sel_fifo_in, sel_fifo_out, sel_fmt,
                  clkdiv_sel, clkdiv_ena, ndiv_ena,
                  output wr_ptr_sync, rd_ptr_sync, fmt_sync, clkdiv_sync, ndiv_sync);
endinterface : sync_if
`default_nettype wire

// >>> rtl/sync_router.sv
`timescale 1ns/100ps
`default_nettype none
module sync_router (
  input wire logic hclk,
  input wire logic hresetn,
  sync_if.router sr
);
  // Sources by mask bit: 0 frame, 1 sync, 2 output strobe, 3 unused
  function automatic logic src_hit(input logic [3:0] sel, input logic fr, input logic sy, input logic os);
    src_hit = (sel[0] & fr) | (sel[1] & sy) | (sel[2] & os);
  endfunction : src_hit

  // Registered one-cycle sync pulses to the datapath blocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr.wr_ptr_sync <= 1'b0;
      sr.rd_ptr_sync <= 1'b0;
      sr.fmt_sync <= 1'b0;
      sr.clkdiv_sync <= 1'b0;
      sr.ndiv_sync <= 1'b0;
    end else begin
      // All-zero select picks no source, so later pulses are ignored
      sr.wr_ptr_sync <= src_hit(sr.sel_fifo_in, sr.frame_rise, sr.sync_rise, sr.output_strobe_rise);
      sr.rd_ptr_sync <= src_hit(sr.sel_fifo_out, sr.frame_rise, sr.sync_rise, sr.output_strobe_rise);
      // Upper select bit set means formatter sync is off
      sr.fmt_sync <= !sr.sel_fmt[1] && (sr.sel_fmt[0] ? sr.sync_rise : sr.frame_rise);
      // Select 0 is the output strobe, which may stay enabled in dual mode
      sr.clkdiv_sync <= sr.clkdiv_ena &&
                        (sr.clkdiv_sel ? (sr.frame_rise | sr.sync_rise) : sr.output_strobe_rise);
      // Sync rising edge resets the PLL feedback dividers when enabled
      sr.ndiv_sync <= sr.ndiv_ena & sr.sync_rise;
    end
  end
endmodule : sync_router
`default_nettype wire

// >>> sim/converter_sync_startup_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module converter_sync_startup_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic lvds_sync_input,
  input wire logic fifo_collision,
  input wire logic dacclk_lost,
  input wire logic tx_active,
  input wire logic output_shutoff,
  input wire logic pll_ndiv_sync,
  input wire logic qmc_offset_ab_sync,
  input wire logic qmc_offset_cd_sync,
  input wire logic qmc_corr_ab_sync,
  input wire logic qmc_corr_cd_sync,
  input wire logic nco_ab_sync,
  input wire logic nco_cd_sync,
  input wire logic [7:0] pll_ref_div_m
);
  logic wa;
  logic nd_pend;
  logic ndiv_q;
  // Write address phase as the slave takes it
  assign wa = hsel && htrans[1] && hready && hwrite;
  // Shadow of the divider sync enable, loaded in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nd_pend <= 1'b0;
      ndiv_q <= 1'b0;
    end else begin
      nd_pend <= wa && haddr[7:2] == 6'h18;
      if (nd_pend) begin
        ndiv_q <= hwdata[11];
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_offset_ab;
    wa && haddr[7:2] == 6'h08 |-> ##2 qmc_offset_ab_sync;
  endproperty
  a_offset_ab: assert property (p_offset_ab) else $error("no AB offset sync");
  property p_offset_cd;
    wa && haddr[7:2] == 6'h0a |-> ##2 qmc_offset_cd_sync;
  endproperty
  a_offset_cd: assert property (p_offset_cd) else $error("no CD offset sync");
  property p_corr_ab;
    wa && haddr[7:2] == 6'h10 |-> ##2 qmc_corr_ab_sync;
  endproperty
  a_corr_ab: assert property (p_corr_ab) else $error("no AB correction sync");
  property p_corr_cd;
    wa && haddr[7:2] == 6'h11 |-> ##2 qmc_corr_cd_sync;
  endproperty
  a_corr_cd: assert property (p_corr_cd) else $error("no CD correction sync");
  property p_nco_ab;
    wa && haddr[7:2] == 6'h12 |-> ##2 nco_ab_sync;
  endproperty
  a_nco_ab: assert property (p_nco_ab) else $error("no AB mixer sync");
  property p_nco_cd;
    wa && haddr[7:2] == 6'h13 |-> ##2 nco_cd_sync;
  endproperty
  a_nco_cd: assert property (p_nco_cd) else $error("no CD mixer sync");
  property p_ndiv;
    $rose(lvds_sync_input) && ndiv_q |-> ##[1:2] pll_ndiv_sync;
  endproperty
  a_ndiv: assert property (p_ndiv) else $error("no feedback divider sync");
  property p_shutoff;
    fifo_collision || dacclk_lost |-> ##2 output_shutoff;
  endproperty
  a_shutoff: assert property (p_shutoff) else $error("output not shut off");
  property p_halt;
    fifo_collision |-> ##2 !tx_active;
  endproperty
  a_halt: assert property (p_halt) else $error("transmit kept after collision");
  property p_pll_m;
    wa && haddr[7:2] == 6'h19 |=> ##2 pll_ref_div_m == $past(hwdata[15:8], 2);
  endproperty
  a_pll_m: assert property (p_pll_m) else $error("reference divider not loaded");
endmodule : converter_sync_startup_checker
bind converter_sync_startup converter_sync_startup_checker #(.ADDR_W(ADDR_W)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .lvds_sync_input(lvds_sync_input), .fifo_collision(fifo_collision),
  .dacclk_lost(dacclk_lost), .tx_active(tx_active), .output_shutoff(output_shutoff),
  .pll_ndiv_sync(pll_ndiv_sync), .qmc_offset_ab_sync(qmc_offset_ab_sync),
  .qmc_offset_cd_sync(qmc_offset_cd_sync), .qmc_corr_ab_sync(qmc_corr_ab_sync),
  .qmc_corr_cd_sync(qmc_corr_cd_sync), .nco_ab_sync(nco_ab_sync),
  .nco_cd_sync(nco_cd_sync), .pll_ref_div_m(pll_ref_div_m)
);
`default_nettype wire

// >>> sim/sync_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sync_host_model (
  input wire logic hclk,
  output logic tx_enable_pin,
  output logic lvds_sync_input,
  output logic lvds_frame_input,
  output logic output_strobe
);
  // Transmit request and sync lines rest low until commanded
  initial begin
    tx_enable_pin = 1'b0;
    lvds_sync_input = 1'b0;
    lvds_frame_input = 1'b0;
    output_strobe = 1'b0;
  end
  // One clean rising edge per event, never a periodic train
  task pulse(input logic [1:0] src);
    @(posedge hclk);
    {output_strobe, lvds_sync_input, lvds_frame_input} <= 3'h1 << src;
    repeat (3) @(posedge hclk);
    {output_strobe, lvds_sync_input, lvds_frame_input} <= 3'h0;
  endtask : pulse
  // Raise or drop the transmit request at the next rising clock edge
  task set_tx(input logic v);
    @(posedge hclk);
    tx_enable_pin <= v;
  endtask : set_tx
endmodule : sync_host_model
`default_nettype wire

// >>> sim/converter_sync_startup_test.sv
`timescale 1ns/100ps
`default_nettype none
module converter_sync_startup_test;
  import conv_pkg::*;
  typedef struct packed {logic [5:0] idx; logic [15:0] val; logic [15:0] exp;} row_t;
  typedef struct packed {logic [5:0] idx; logic [15:0] val; logic [1:0] src; logic [4:0] exp;} sync_row_t;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic tx_pin, sync_in, frame_in, output_strobe_in, tx_active, output_shutoff, alarm_out;
  logic [1:0] htrans = 2'h0, bias;
  logic [2:0] hsize = 3'h2, fofs;
  logic [3:0] ev = 4'h0, mix;
  logic [4:0] n_div;
  logic [7:0] haddr = 8'h00, m_div;
  logic [31:0] hwdata = 32'h0, hrdata, rdat;
  wire logic [4:0] pulses;
  freq_word_t fw_ab, fw_cd;
  int n_errors = 0, checks = 0, cyc = 0, cnt[5] = '{default: 0}, snap[5];
  logic [15:0] abit[3] = '{16'h2000, 16'h0400, 16'h0200};
  // Written value, expected read-back; the last three are refused places
  row_t rows[26] = '{'{6'h00, 16'hf29f, 16'hf29f}, '{6'h01, 16'h050e, 16'h050e}, '{6'h02, 16'hf052, 16'hf052},
    '{6'h03, 16'ha000, 16'ha000}, '{6'h07, 16'hd8ff, 16'hd8ff}, '{6'h08, 16'h1234, 16'h1234},
    '{6'h09, 16'he00a, 16'he00a}, '{6'h0a, 16'h5678, 16'h5678}, '{6'h0b, 16'h9abc, 16'h9abc},
    '{6'h0c, 16'h0400, 16'h0400}, '{6'h0d, 16'h3401, 16'h3401}, '{6'h0e, 16'h0401, 16'h0401},
    '{6'h0f, 16'h0402, 16'h0402}, '{6'h10, 16'h0011, 16'h0011}, '{6'h11, 16'h0022, 16'h0022},
    '{6'h12, 16'h0033, 16'h0033}, '{6'h13, 16'h0044, 16'h0044}, '{6'h14, 16'h999a, 16'h999a},
    '{6'h15, 16'h1999, 16'h1999}, '{6'h16, 16'h999a, 16'h999a}, '{6'h17, 16'h1999, 16'h1999},
    '{6'h18, 16'h2c58, 16'h2c58}, '{6'h19, 16'h20f4, 16'h20f4}, '{6'h06, 16'h1234, 16'h0000},
    '{6'h30, 16'h1234, 16'h0000}, '{6'h21, 16'hffff, 16'h0008}};
  row_t rst_rows[6] = '{'{6'h00, 16'h0, 16'h049c}, '{6'h01, 16'h0, 16'h050e}, '{6'h02, 16'h0, 16'h7000},
    '{6'h03, 16'h0, 16'hf000}, '{6'h07, 16'h0, 16'hffff}, '{6'h19, 16'h0, 16'h0000}};
  // Setup write, source (0 frame, 1 sync, 2 strobe), expected {wr, rd, fmt, clkdiv, ndiv}
  sync_row_t srows[11] = '{'{6'h18, 16'h2c58, 2'h1, 5'b00001}, '{6'h18, 16'h2458, 2'h1, 5'b00000},
    '{6'h20, 16'h2201, 2'h1, 5'b11010}, '{6'h1f, 16'h0004, 2'h1, 5'b11110}, '{6'h1f, 16'h0008, 2'h1, 5'b11010},
    '{6'h1f, 16'h000c, 2'h1, 5'b11010}, '{6'h00, 16'hf29b, 2'h1, 5'b11000}, '{6'h20, 16'h0000, 2'h1, 5'b00000},
    '{6'h00, 16'hf29f, 2'h2, 5'b00010}, '{6'h1f, 16'h0000, 2'h0, 5'b00100}, '{6'h20, 16'h1100, 2'h0, 5'b11100}};
  converter_sync_startup #(.ADDR_W(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_enable_pin(tx_pin), .lvds_sync_input(sync_in), .lvds_frame_input(frame_in),
    .output_strobe(output_strobe_in), .dataclk_lost(ev[2]), .dacclk_lost(ev[1]), .fifo_collision(ev[0]),
    .pll_unlock(ev[3]), .tx_active(tx_active), .output_shutoff(output_shutoff), .alarm_out(alarm_out),
    .fifo_wr_ptr_sync(pulses[4]), .fifo_rd_ptr_sync(pulses[3]), .formatter_sync(pulses[2]),
    .clkdiv_sync(pulses[1]), .pll_ndiv_sync(pulses[0]), .qmc_offset_ab_sync(), .qmc_offset_cd_sync(),
    .qmc_corr_ab_sync(), .qmc_corr_cd_sync(), .nco_ab_sync(), .nco_cd_sync(),
    .oscillator_frequency_word_ab(fw_ab), .oscillator_frequency_word_cd(fw_cd), .pll_ref_div_m(m_div),
    .pll_fb_div_n(n_div), .pll_vco_bias(bias), .coarse_mixer_mode(mix), .fifo_offset(fofs)
  );
  sync_host_model i_host (.hclk(hclk), .tx_enable_pin(tx_pin), .lvds_sync_input(sync_in),
    .lvds_frame_input(frame_in), .output_strobe(output_strobe_in));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Single word transfer: hold the address phase, then the data phase, each until hready
  task bus(input logic wr, input logic [5:0] idx, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {16'hdead, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    check({hresp, hreadyout}, 32'h1);
  endtask : bus
  // Let outputs settle before sampling them
  task settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : settle
  // One-cycle alarm event on line j
  task fire(input int j);
    @(posedge hclk);
    ev <= 4'h1 << j;
    @(posedge hclk);
    ev <= 4'h0;
  endtask : fire
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Pulse counters and the hang limit
  always @(posedge hclk) begin
    cyc++;
    for (int j = 0; j < 5; j++) begin
      if (pulses[j] === 1'b1) cnt[j]++;
    end
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].val);
      bus(1'b0, rows[i].idx, 16'h0000);
      check(rdat, {16'h0, rows[i].exp});
    end
    settle(1);
    check(fw_ab, 32'h1999999a);
    check(fw_cd, 32'h1999999a);
    check({m_div, 3'h0, n_div}, {8'h20, 8'h10});
    check({bias, fofs, mix}, {2'h1, 3'h7, 4'h3});
    // Sync routing under each formatter and clock-divider select, FIFO selects of frame, sync or none, and both enable settings
    foreach (srows[i]) begin
      bus(1'b1, srows[i].idx, srows[i].val);
      snap = cnt;
      i_host.pulse(srows[i].src);
      settle(6);
      for (int j = 0; j < 5; j++) begin
        check(cnt[j] - snap[j], {31'h0, srows[i].exp[j]});
      end
    end
    // Each unmasked fault stops transmission, shuts off and raises the alarm
    for (int j = 0; j < 3; j++) begin
      i_host.set_tx(1'b1);
      settle(2);
      check(tx_active, 1'b1);
      fire(j);
      settle(3);
      check({output_shutoff, alarm_out, tx_active}, 3'b110);
      bus(1'b0, 6'h05, 16'h0000);
      check(rdat, {16'h0, abit[j]});
      i_host.set_tx(1'b0);
      bus(1'b1, 6'h05, 16'h0000);
      bus(1'b0, 6'h21, 16'h0000);
      check(rdat, 32'h8);
    end
    fire(3);
    settle(3);
    check({output_shutoff, alarm_out}, 2'b00);
    bus(1'b0, 6'h05, 16'h0000);
    check(rdat, 32'h1000);
    bus(1'b1, 6'h05, 16'h0000);
    bus(1'b1, 6'h03, 16'ha001);
    settle(2);
    check(tx_active, 1'b1);
    bus(1'b1, 6'h03, 16'ha000);
    // Second reset in mid-run restores the reset values
    @(posedge hclk);
    hresetn <= 1'b0;
    settle(5);
    check({tx_active, output_shutoff, alarm_out}, 3'b000);
    @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_rows[i]) begin
      bus(1'b0, rst_rows[i].idx, 16'h0000);
      check(rdat, {16'h0, rst_rows[i].exp});
    end
    check(n_div, 5'h1);
    wrap_up();
  end
endmodule : converter_sync_startup_test
`default_nettype wire
